/* File: src/dsrc_reset_combiner.sv */
`timescale 1ns/1ns

module dsrc_reset_combiner (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [dsrc_pkg::NUM_SUB-1:0] supplyOk,
    input wire dsrc_pkg::dsrc_req_t resetReq,
    input wire logic controlSubsysReleaseBit,
    input wire logic analogSubsysReleaseBit,
    input wire logic analogResetPinIn,
    output logic analogResetPinOut,
    output logic analogResetPinOe_n,
    input wire logic digitalResetPinIn,
    output logic digitalResetPinOut,
    output logic digitalResetPinOe_n,
    output dsrc_pkg::dsrc_rst_t subsysRst,
    output logic gpioHiZ
);

    // ==========================================================
    // input synchronisers (supply-good levels and reset pins)
    logic [dsrc_pkg::NUM_SUB-1:0] supSync1_r;
    logic [dsrc_pkg::NUM_SUB-1:0] supSync2_r;
    logic [dsrc_pkg::NUM_SUB-1:0] pinSync1_r;
    logic [dsrc_pkg::NUM_SUB-1:0] pinSync2_r;
    logic [dsrc_pkg::NUM_SUB-1:0] pinRaw;

    assign pinRaw[dsrc_pkg::SUB_DIG] = digitalResetPinIn;
    assign pinRaw[dsrc_pkg::SUB_ANA] = analogResetPinIn;

    // second stages are the only readers of the first; nothing else sees a metastable level
    logic [dsrc_pkg::NUM_SUB-1:0] supSync1_nxt;
    logic [dsrc_pkg::NUM_SUB-1:0] supSync2_nxt;
    logic [dsrc_pkg::NUM_SUB-1:0] pinSync1_nxt;
    logic [dsrc_pkg::NUM_SUB-1:0] pinSync2_nxt;

    always_comb begin
        supSync1_nxt = supplyOk;
        supSync2_nxt = supSync1_r;
        pinSync1_nxt = pinRaw;
        pinSync2_nxt = pinSync1_r;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            supSync1_r <= '0;
            supSync2_r <= '0;
            pinSync1_r <= '0;
            pinSync2_r <= '0;
        end else begin
            supSync1_r <= supSync1_nxt;
            supSync2_r <= supSync2_nxt;
            pinSync1_r <= pinSync1_nxt;
            pinSync2_r <= pinSync2_nxt;
        end
    end

    // ==========================================================
    // power-on generators, one per subsystem, no enable input
    logic [dsrc_pkg::NUM_SUB-1:0] porActive;

    genvar s;
    generate
        for (s = 0; s < dsrc_pkg::NUM_SUB; s++) begin : g_por
            logic [dsrc_pkg::CNT_W-1:0] cnt_r;
            logic [dsrc_pkg::CNT_W-1:0] cnt_nxt;
            logic active_r;
            logic active_nxt;

            // a supply dip restarts the full pulse rather than resuming the count
            always_comb begin
                cnt_nxt = cnt_r;
                active_nxt = active_r;
                if (!supSync2_r[s]) begin
                    cnt_nxt = dsrc_pkg::CNT_ZERO;
                    active_nxt = 1'b1;
                end else if (active_r) begin
                    if (cnt_r == dsrc_pkg::POR_LAST) begin
                        active_nxt = 1'b0;
                    end else begin
                        cnt_nxt = cnt_r + dsrc_pkg::CNT_ONE;
                    end
                end
            end

            // no enable term exists, so nothing in software can suppress the pulse
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    cnt_r <= dsrc_pkg::CNT_ZERO;
                    active_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_nxt;
                    active_r <= active_nxt;
                end
            end

            assign porActive[s] = active_r;
        end
    endgenerate

    // ==========================================================
    // digital request combining and pin drive
    logic anyReq;
    logic [dsrc_pkg::CNT_W-1:0] reqCnt_r;
    logic [dsrc_pkg::CNT_W-1:0] reqCnt_nxt;
    logic reqActive;
    logic anyPor;
    logic digDrive;
    logic anaDrive;
    logic digOe_n_r;
    logic anaOe_n_r;
    logic gpioHiZ_r;
    logic digOe_n_nxt;
    logic anaOe_n_nxt;
    logic gpioHiZ_nxt;
    logic digOut_r;
    logic anaOut_r;

    assign anyReq = |resetReq;
    // a one-cycle request is stretched so other ICs on the pin see it
    assign reqActive = anyReq || (reqCnt_r != dsrc_pkg::CNT_ZERO);
    assign anyPor = |porActive;
    // either generator pulls both pins while its supply ramps
    assign digDrive = anyPor || reqActive;
    assign anaDrive = anyPor;

    // limitation: a request that never drops keeps the pin low forever; there is no timeout
    always_comb begin
        reqCnt_nxt = reqCnt_r;
        if (anyReq) begin
            reqCnt_nxt = dsrc_pkg::REQ_LAST;
        end else if (reqCnt_r != dsrc_pkg::CNT_ZERO) begin
            reqCnt_nxt = reqCnt_r - dsrc_pkg::CNT_ONE;
        end
        digOe_n_nxt = digDrive ? dsrc_pkg::OE_DRIVE : dsrc_pkg::OE_FLOAT;
        anaOe_n_nxt = anaDrive ? dsrc_pkg::OE_DRIVE : dsrc_pkg::OE_FLOAT;
        gpioHiZ_nxt = anyPor;
    end

    // open-drain data side stays low; only the enables move
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reqCnt_r <= dsrc_pkg::CNT_ZERO;
            digOe_n_r <= dsrc_pkg::OE_DRIVE;
            anaOe_n_r <= dsrc_pkg::OE_DRIVE;
            gpioHiZ_r <= 1'b1;
            digOut_r <= dsrc_pkg::PIN_LOW;
            anaOut_r <= dsrc_pkg::PIN_LOW;
        end else begin
            reqCnt_r <= reqCnt_nxt;
            digOe_n_r <= digOe_n_nxt;
            anaOe_n_r <= anaOe_n_nxt;
            gpioHiZ_r <= gpioHiZ_nxt;
            digOut_r <= dsrc_pkg::PIN_LOW;
            anaOut_r <= dsrc_pkg::PIN_LOW;
        end
    end

    assign digitalResetPinOut = digOut_r;
    assign analogResetPinOut = anaOut_r;
    assign digitalResetPinOe_n = digOe_n_r;
    assign analogResetPinOe_n = anaOe_n_r;
    assign gpioHiZ = gpioHiZ_r;

    // ==========================================================
    // per-subsystem reset holds and release synchronisers
    logic digHold;
    logic anaHold;
    logic [dsrc_pkg::NUM_RST-1:0] hold;
    logic [dsrc_pkg::NUM_RST-1:0] relDone;

    // the sampled pin level lets an external or joined-pin low hold us in reset
    assign digHold = !rst_n || anyPor || reqActive || !pinSync2_r[dsrc_pkg::SUB_DIG];
    assign anaHold = !rst_n || anyPor || !pinSync2_r[dsrc_pkg::SUB_ANA];
    assign hold[dsrc_pkg::RST_MASTER] = digHold;
    assign hold[dsrc_pkg::RST_CONTROL] = digHold || !controlSubsysReleaseBit;
    assign hold[dsrc_pkg::RST_ANALOG] = anaHold || !analogSubsysReleaseBit;

    // one synchroniser per reset, so each subsystem leaves reset on its own clean edge
    genvar r;
    generate
        for (r = 0; r < dsrc_pkg::NUM_RST; r++) begin : g_rsync
            logic stage1_r;
            logic stage2_r;
            logic stage1_nxt;
            logic stage2_nxt;

            always_comb begin
                stage1_nxt = 1'b1;
                stage2_nxt = stage1_r;
            end

            // assertion may be glitchy but only ever forces the safe state
            always_ff @(posedge mclk or posedge hold[r]) begin
                if (hold[r]) begin
                    stage1_r <= 1'b0;
                    stage2_r <= 1'b0;
                end else begin
                    stage1_r <= stage1_nxt;
                    stage2_r <= stage2_nxt;
                end
            end

            assign relDone[r] = stage2_r;
        end
    endgenerate

    assign subsysRst.master_n = relDone[dsrc_pkg::RST_MASTER];
    assign subsysRst.control_n = relDone[dsrc_pkg::RST_CONTROL];
    assign subsysRst.analog_n = relDone[dsrc_pkg::RST_ANALOG];

endmodule

/* File: src/dsrc_pkg.sv */
package dsrc_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 4;
    // power-on pulse length after both supply-good levels settle
    localparam int POR_TIME_NS = 1000;
    localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // least time the digital pin is pulled low for a one-cycle request
    localparam int REQ_PULSE_NS = 100;
    localparam int REQ_PULSE_CYCLES = (REQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_CYCLES - 1);
    localparam logic [CNT_W-1:0] REQ_LAST = CNT_W'(REQ_PULSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // ==========================================================
    // subsystem indices and pin levels
    localparam int SUB_DIG = 0;
    localparam int SUB_ANA = 1;
    localparam int NUM_SUB = 2;
    localparam int NUM_RST = 3;
    localparam int RST_MASTER = 0;
    localparam int RST_CONTROL = 1;
    localparam int RST_ANALOG = 2;
    localparam logic PIN_LOW = 1'b0;
    localparam logic OE_DRIVE = 1'b0;
    localparam logic OE_FLOAT = 1'b1;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic interruptCtrlResetRequest;
        logic wdog0;
        logic wdog1;
        logic nmiWdog;
    } dsrc_req_t;

    typedef struct packed {
        logic analog_n;
        logic control_n;
        logic master_n;
    } dsrc_rst_t;

endpackage

/* File: tb/dsrc_board_model.sv */
`timescale 1ns/1ns
// ====================
// board reset network
module dsrc_board_model (
    input wire logic anaOe_n,
    input wire logic anaOut,
    input wire logic digOe_n,
    input wire logic digOut,
    input wire logic extPull_n,
    input wire logic joined,
    output logic anaPin,
    output logic digPin
);
    // pull-ups on both open-drain nodes; a driven pin shows the device's data level
    logic anaNode;
    logic digNode;
    assign anaNode = (anaOe_n | anaOut) & extPull_n;
    assign digNode = (digOe_n | digOut) & extPull_n;
    assign anaPin = joined ? anaNode & digNode : anaNode;
    assign digPin = joined ? anaNode & digNode : digNode;
endmodule

/* File: tb/dsrc_reset_combiner_chk.sv */
`timescale 1ns/1ns
module dsrc_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire dsrc_pkg::dsrc_req_t resetReq,
    input wire logic controlSubsysReleaseBit,
    input wire logic digitalResetPinIn,
    input wire logic digitalResetPinOe_n,
    input wire logic analogResetPinOe_n,
    input wire dsrc_pkg::dsrc_rst_t subsysRst,
    input wire logic gpioHiZ
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // first part of the stretch; its full length is measured by the bench
    sequence s_held;
        !digitalResetPinOe_n [*8];
    endsequence
    a_req_pulls_pin: assert property (|resetReq |=> !digitalResetPinOe_n)
        else $error("request did not pull pin");
    a_req_stretch: assert property ($fell(|resetReq) |-> s_held)
        else $error("pin released too early");
    a_req_holds_master: assert property (|resetReq |=> !subsysRst.master_n)
        else $error("master left running");
    a_por_pins_low: assert property (gpioHiZ |-> !digitalResetPinOe_n && !analogResetPinOe_n)
        else $error("pins float in power-on");
    a_por_clears_all: assert property (gpioHiZ |-> subsysRst == '0)
        else $error("logic not held in power-on");
    a_pin_low_holds: assert property ($fell(digitalResetPinIn) |-> ##[0:3] !subsysRst.master_n && !subsysRst.control_n)
        else $error("low pin ignored");
    a_control_waits: assert property (!controlSubsysReleaseBit |-> !subsysRst.control_n)
        else $error("control left reset unasked");
    a_master_sync_rel: assert property ($rose(subsysRst.master_n) |-> $past(digitalResetPinIn) && $past(digitalResetPinIn, 2))
        else $error("release not synchronised");
endmodule
bind dsrc_reset_combiner dsrc_chk chk (.mclk(mclk), .rst_n(rst_n), .resetReq(resetReq),
    .controlSubsysReleaseBit(controlSubsysReleaseBit), .digitalResetPinIn(digitalResetPinIn),
    .digitalResetPinOe_n(digitalResetPinOe_n), .analogResetPinOe_n(analogResetPinOe_n),
    .subsysRst(subsysRst), .gpioHiZ(gpioHiZ));

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic mclk = 0, rst_n = 0, ctlRel = 0, anaRel = 0, extPull_n = 1, joined = 1;
    logic [1:0] supplyOk = 2'h0;
    dsrc_pkg::dsrc_req_t resetReq = '0;
    logic anaIn, anaOut, anaOe_n, digIn, digOut, digOe_n, gpioHiZ;
    dsrc_pkg::dsrc_rst_t subsysRst;
    int mismatches = 0, tests_run = 0, cyc = 0, n;
    logic [31:0] seed = 32'h69DA293E;
    always #2 mclk = ~mclk;
    dsrc_reset_combiner DUT (.mclk(mclk), .rst_n(rst_n), .supplyOk(supplyOk), .resetReq(resetReq),
        .controlSubsysReleaseBit(ctlRel), .analogSubsysReleaseBit(anaRel), .analogResetPinIn(anaIn),
        .analogResetPinOut(anaOut), .analogResetPinOe_n(anaOe_n), .digitalResetPinIn(digIn),
        .digitalResetPinOut(digOut), .digitalResetPinOe_n(digOe_n), .subsysRst(subsysRst), .gpioHiZ(gpioHiZ));
    dsrc_board_model board (.anaOe_n(anaOe_n), .anaOut(anaOut), .digOe_n(digOe_n), .digOut(digOut),
        .extPull_n(extPull_n), .joined(joined), .anaPin(anaIn), .digPin(digIn));
    // ====================
    // helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // registered stretch: one cycle of slack either way
    function automatic logic lowOk(input int got, input int reqLen);
        return got >= reqLen - 2 + dsrc_pkg::REQ_PULSE_CYCLES && got <= reqLen + dsrc_pkg::REQ_PULSE_CYCLES;
    endfunction
    task automatic check(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            results();
        end
    end
    // ====================
    // scenarios
    initial begin
        repeat (6) @(negedge mclk);
        rst_n = 1;
        repeat (4) @(negedge mclk);
        check(gpioHiZ && !digOe_n && !anaOe_n && subsysRst === 3'b000, "power-on hold");
        check(digOut === 1'b0 && anaOut === 1'b0, "pin data low");
        supplyOk = 2'h1;
        repeat (20) @(negedge mclk);
        check(gpioHiZ && !anaOe_n, "analog power-on");
        supplyOk = 2'h3;
        for (n = 0; n < 300 && gpioHiZ; n++) @(negedge mclk);
        check(n >= dsrc_pkg::POR_CYCLES - 1 && n < 300, "power-on length");
        for (n = 0; n < 20 && subsysRst.master_n !== 1'b1; n++) @(negedge mclk);
        check(subsysRst === 3'b001, "only master");
        ctlRel = 1;
        repeat (8) @(negedge mclk);
        check(subsysRst === 3'b011, "control release");
        anaRel = 1;
        repeat (8) @(negedge mclk);
        check(subsysRst === 3'b111, "analog release");
        ctlRel = 0;
        repeat (2) @(negedge mclk);
        check(subsysRst === 3'h5, "control re-held");
        ctlRel = 1;
        repeat (8) @(negedge mclk);
        check(subsysRst === 3'h7, "control re-release");
        for (int i = 0; i < 4; i++) begin
            resetReq = 4'h1 << i;
            @(negedge mclk);
            resetReq = '0;
            check(!subsysRst.master_n && !subsysRst.control_n && !digOe_n, "request reset");
            for (n = 0; n < 60 && !digOe_n; n++) @(negedge mclk);
            check(lowOk(n, 1), "stretch length");
            for (n = 0; n < 20 && subsysRst !== 3'b111; n++) @(negedge mclk);
            check(subsysRst === 3'h7, "request recovery");
        end
        // random bursts, back to back and overlapping
        for (int k = 0; k < 30; k++) begin
            seed = xorshift(seed);
            resetReq = seed[3:0];
            repeat (1 + seed[6:4]) @(negedge mclk);
        end
        resetReq = '0;
        for (n = 0; n < 60 && subsysRst !== 3'b111; n++) @(negedge mclk);
        check(subsysRst === 3'b111, "burst recovery");
        seed = xorshift(seed);
        extPull_n = 0;
        repeat (40 + seed[4:0]) @(negedge mclk);
        check(subsysRst === 3'b000 && gpioHiZ === 1'b0, "external hold");
        extPull_n = 1;
        for (n = 0; n < 60 && subsysRst !== 3'b111; n++) @(negedge mclk);
        check(subsysRst === 3'b111, "joint release");
        joined = 0;
        resetReq = 4'h8;
        @(negedge mclk);
        resetReq = '0;
        check(!subsysRst.master_n && subsysRst.analog_n === 1'b1 && anaOe_n === 1'b1, "split request");
        for (n = 0; n < 60 && subsysRst !== 3'h7; n++) @(negedge mclk);
        check(subsysRst === 3'h7, "split recovery");
        joined = 1;
        supplyOk = 2'h2;
        repeat (5) @(negedge mclk);
        check(gpioHiZ && subsysRst === 3'b000 && !anaOe_n && !digOe_n, "brownout");
        extPull_n = 0;
        supplyOk = 2'h3;
        for (n = 0; n < 300 && gpioHiZ; n++) @(negedge mclk);
        repeat (20) @(negedge mclk);
        check(!gpioHiZ && subsysRst === 3'h0 && digOe_n && anaOe_n, "reset extended");
        extPull_n = 1;
        for (n = 0; n < 20 && subsysRst !== 3'h7; n++) @(negedge mclk);
        check(subsysRst === 3'h7, "extended release");
        results();
    end
endmodule
